// *** rtl/psf_pkg.sv ***
package psf_pkg;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_SEL_DELAY  = 8'h04;
	localparam logic [7:0] ADDR_SPECIAL    = 8'h08;
	localparam logic [7:0] ADDR_TOL_AB     = 8'h0c;
	localparam logic [7:0] ADDR_TOL_Z      = 8'h10;
	localparam logic [7:0] ADDR_TOL_S      = 8'h14;
	localparam logic [7:0] ADDR_STANDSTILL = 8'h18;
	localparam logic [7:0] ADDR_OVERSPEED  = 8'h1c;
	localparam logic [7:0] ADDR_RATIO      = 8'h20;
	localparam logic [7:0] ADDR_VOLT_LIM   = 8'h24;
	localparam logic [7:0] ADDR_STATUS     = 8'h28;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_BASIC_LSB = 2;
	localparam int CTRL_IDX_PNP   = 4;
	localparam int CTRL_SUPV_VOLT = 5;
	localparam int VOLT_HI_LSB    = 16;
	localparam int STAT_ERR_LSB   = 4;
	localparam int STAT_OUT_LSB   = 12;
	localparam int STAT_RESTART   = 20;

	// error bits
	localparam int ERR_AB    = 0;
	localparam int ERR_Z     = 1;
	localparam int ERR_S     = 2;
	localparam int ERR_PLAUS = 3;
	localparam int ERR_FMAX  = 4;
	localparam int ERR_SEL   = 5;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [5:0]  RST_CTRL      = 6'h00;
	localparam logic [15:0] RST_SEL_DELAY = 16'h0000;
	localparam logic [31:0] RST_SPECIAL   = 32'h0000_0000;
	localparam logic [15:0] RST_TOL       = 16'h0000;
	localparam logic [23:0] RST_THRESHOLD = 24'h00_0000;
	localparam logic [7:0]  RST_RATIO     = 8'h01;
	localparam logic [15:0] RST_VOLT_LO   = 16'h0000;
	localparam logic [15:0] RST_VOLT_HI   = 16'h7530;

	// ****************************************
	// basic configuration figures
	// ****************************************
	localparam logic [23:0] PROX_STANDSTILL_HZ = 24'd2;
	localparam logic [23:0] PROX_OVERSPEED_HZ  = 24'd500;
	localparam logic [23:0] PROX_FMAX_HZ       = 24'd3500;
	localparam logic [23:0] ENC_STANDSTILL_HZ  = 24'd100;
	localparam logic [23:0] ENC_OVERSPEED_HZ   = 24'd5000;
	localparam logic [23:0] ENC_FMAX_HZ        = 24'd1000000;
	localparam logic [23:0] HYST_DIVISOR       = 24'd50;
	localparam logic [3:0]  WRONG_DIR_PULSES   = 4'd10;
	localparam logic [15:0] SUPV_MAX_MV        = 16'd30000;

	typedef enum logic [1:0] {
		SEL_NONE        = 2'h0,
		SEL_ONE_OF_FOUR = 2'h1,
		SEL_ALL16       = 2'h2
	} sel_mode_t;

	typedef enum logic [1:0] {
		BASIC_OFF     = 2'h0,
		BASIC_PROX    = 2'h1,
		BASIC_ENCODER = 2'h2
	} basic_t;

	typedef enum logic [1:0] {
		SPF_NONE    = 2'h0,
		SPF_NO_DIAG = 2'h1,
		SPF_ACK     = 2'h2,
		SPF_RESTART = 2'h3
	} special_t;

endpackage

// *** rtl/tol_filter.sv ***
`timescale 1ns/1ps
module tol_filter import psf_pkg::*; #(
	parameter int W = 16
) (
	input  wire logic         core_clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         clear_i,
	input  wire logic         invalid_i,
	input  wire logic [W-1:0] tol_i,
	output logic              fault_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         fault;
	} filt_t;

	filt_t st_reg;
	filt_t st_next;

	// leaky count: short bursts drain away, so a chattering level may take
	// several tolerance windows before it is reported
	always_comb begin
		st_next = st_reg;
		if (clear_i) begin
			st_next = '0;
		end else if (invalid_i) begin
			if (st_reg.cnt != '1)
				st_next.cnt = st_reg.cnt + W'(1);
		end else if (st_reg.cnt != '0) begin
			st_next.cnt = st_reg.cnt - W'(1);
		end
		st_next.fault = !clear_i && invalid_i && (st_reg.cnt >= tol_i);
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign fault_o = st_reg.fault;
endmodule

// *** rtl/param_set_special_functions.sv ***
`timescale 1ns/1ps
module param_set_special_functions import psf_pkg::*; (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic        wr_en_i,
	input  wire logic        rd_en_i,
	output logic [31:0]      rd_data_o,
	input  wire logic [3:0]  sel_i,
	input  wire logic        ab_invalid_i,
	input  wire logic        z_invalid_i,
	input  wire logic        supervision_fault_i,
	input  wire logic [15:0] supervision_mv_i,
	input  wire logic [23:0] ab_track_frequency_i,
	input  wire logic [23:0] index_track_frequency_i,
	input  wire logic        dir_pulse_i,
	input  wire logic        dir_left_i,
	output logic             relay_out_one_o,
	output logic             relay_out_two_o,
	output logic             semi_out_one_o,
	output logic             semi_out_two_o,
	output logic             semi_out_three_o,
	output logic             semi_out_four_o,
	output logic             external_out_one_o,
	output logic             external_out_two_o,
	output logic             restart_o,
	output logic [3:0]       active_set_o
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [6:0]  pin_meta;
		logic [6:0]  pin_sync;
		logic [3:0]  cand;
		logic [15:0] dly_cnt;
		logic [3:0]  active;
		logic        set_chg;
		logic [3:0]  fired_idx;
		logic        armed;
		logic [5:0]  ctrl;
		logic [15:0] sel_delay;
		logic [31:0] special;
		logic [15:0] tol_ab;
		logic [15:0] tol_z;
		logic [15:0] tol_s;
		logic [23:0] standstill;
		logic [23:0] overspeed;
		logic [7:0]  ratio;
		logic [15:0] volt_lo;
		logic [15:0] volt_hi;
		logic [5:0]  err;
		logic        restart;
		logic        stand_on;
		logic        speed_ok;
		logic [3:0]  wrong_l;
		logic [3:0]  wrong_r;
		logic [7:0]  outs;
		logic [31:0] rd_data;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic        ab_fault;
	logic        z_fault;
	logic        s_fault;
	logic [15:0] z_tol;
	logic        idx_pnp;
	logic        filt_clear;

	assign idx_pnp    = st_reg.ctrl[CTRL_IDX_PNP];
	assign filt_clear = st_reg.restart;
	// index track shares the ab tolerance unless it is a pnp switch
	assign z_tol = idx_pnp ? st_reg.tol_z : st_reg.tol_ab;

	// ****************************************
	// level filters
	// ****************************************
	tol_filter #(.W(16)) u_filt_ab (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.clear_i    (filt_clear),
		.invalid_i  (st_reg.pin_sync[0]),
		.tol_i      (st_reg.tol_ab),
		.fault_o    (ab_fault)
	);

	tol_filter #(.W(16)) u_filt_z (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.clear_i    (filt_clear),
		.invalid_i  (st_reg.pin_sync[1]),
		.tol_i      (z_tol),
		.fault_o    (z_fault)
	);

	tol_filter #(.W(16)) u_filt_s (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.clear_i    (filt_clear),
		.invalid_i  (st_reg.pin_sync[2] && !st_reg.ctrl[CTRL_SUPV_VOLT]),
		.tol_i      (st_reg.tol_s),
		.fault_o    (s_fault)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [1:0]  mode;
		logic [1:0]  basic;
		logic        spf_allowed;
		logic [3:0]  sel_now;
		logic [3:0]  commit_set;
		logic        commit;
		logic        onehot_ok;
		logic [1:0]  spf;
		logic [23:0] thr_stand;
		logic [23:0] thr_speed;
		logic [23:0] fmax;
		logic [23:0] f_ab;
		logic [31:0] expect_ab;
		logic [31:0] margin;
		logic        plaus_bad;
		logic        volt_bad;
		logic [5:0]  err_now;
		logic        fire_ack;
		logic        fire_restart;
		logic        left_ok;
		logic        right_ok;
		logic        run;

		mode         = '0;
		basic        = '0;
		spf_allowed  = 1'b0;
		sel_now      = '0;
		commit_set   = '0;
		commit       = 1'b0;
		onehot_ok    = 1'b0;
		spf          = '0;
		thr_stand    = '0;
		thr_speed    = '0;
		fmax         = '0;
		f_ab         = '0;
		expect_ab    = '0;
		margin       = '0;
		plaus_bad    = 1'b0;
		volt_bad     = 1'b0;
		err_now      = '0;
		fire_ack     = 1'b0;
		fire_restart = 1'b0;
		left_ok      = 1'b0;
		right_ok     = 1'b0;
		run          = 1'b0;
		st_next      = st_reg;

		// pins pass two flip-flops before anything reads them
		st_next.pin_meta = {sel_i, supervision_fault_i, z_invalid_i, ab_invalid_i};
		st_next.pin_sync = st_reg.pin_meta;

		mode  = st_reg.ctrl[CTRL_MODE_LSB +: 2];
		basic = st_reg.ctrl[CTRL_BASIC_LSB +: 2];
		spf_allowed = (basic == BASIC_OFF) &&
			(mode == SEL_ONE_OF_FOUR || mode == SEL_ALL16);

		// ****************************************
		// set selection
		// ****************************************
		sel_now   = st_reg.pin_sync[6:3];
		onehot_ok = (sel_now == 4'h1) || (sel_now == 4'h2) ||
			(sel_now == 4'h4) || (sel_now == 4'h8);
		if (sel_now != st_reg.cand) begin
			st_next.cand    = sel_now;
			st_next.dly_cnt = '0;
		end else if (st_reg.dly_cnt < st_reg.sel_delay) begin
			st_next.dly_cnt = st_reg.dly_cnt + 16'h0001;
		end else begin
			commit = 1'b1;
		end
		if (basic != BASIC_OFF || mode == SEL_NONE) begin
			commit_set = 4'h0;
		end else if (mode == SEL_ONE_OF_FOUR && !(commit && onehot_ok)) begin
			commit_set = st_reg.active;
		end else begin
			commit_set = commit ? st_reg.cand : st_reg.active;
		end
		st_next.active  = commit_set;
		st_next.set_chg = (commit_set != st_reg.active);

		// ****************************************
		// one-shot special functions
		// ****************************************
		spf = st_reg.special[{st_reg.active, 1'b0} +: 2];
		if (!spf_allowed)
			spf = SPF_NONE;
		if (st_reg.active != st_reg.fired_idx)
			st_next.armed = 1'b1;
		if (st_reg.set_chg && (st_reg.armed || st_reg.active != st_reg.fired_idx)) begin
			fire_ack     = (spf == SPF_ACK);
			fire_restart = (spf == SPF_RESTART) || fire_ack;
		end
		if (fire_restart) begin
			st_next.armed     = 1'b0;
			st_next.fired_idx = st_reg.active;
		end
		st_next.restart = fire_restart;

		// ****************************************
		// thresholds and monitoring
		// ****************************************
		case (basic)
			BASIC_PROX: begin
				thr_stand = PROX_STANDSTILL_HZ;
				thr_speed = PROX_OVERSPEED_HZ;
				fmax      = PROX_FMAX_HZ;
			end
			BASIC_ENCODER: begin
				thr_stand = ENC_STANDSTILL_HZ;
				thr_speed = ENC_OVERSPEED_HZ;
				fmax      = ENC_FMAX_HZ;
			end
			default: begin
				thr_stand = RST_THRESHOLD;
				thr_speed = RST_THRESHOLD;
				fmax      = '1;
			end
		endcase
		if (st_reg.standstill != RST_THRESHOLD)
			thr_stand = st_reg.standstill;
		if (st_reg.overspeed != RST_THRESHOLD)
			thr_speed = st_reg.overspeed;

		f_ab = ab_track_frequency_i;
		// 2 % hysteresis band on both switch points
		if (f_ab < thr_stand)
			st_next.stand_on = 1'b1;
		else if (f_ab > thr_stand + thr_stand / HYST_DIVISOR)
			st_next.stand_on = 1'b0;
		if (f_ab > thr_speed)
			st_next.speed_ok = 1'b0;
		else if (f_ab < thr_speed - thr_speed / HYST_DIVISOR)
			st_next.speed_ok = 1'b1;

		// ratio check; an eighth of the ab frequency is the allowed slack
		expect_ab = 32'(index_track_frequency_i) * 32'(st_reg.ratio);
		margin    = {8'h00, f_ab >> 3};
		plaus_bad = ({8'h00, f_ab} > expect_ab + margin) ||
			({8'h00, f_ab} + margin < expect_ab);
		if (spf == SPF_NO_DIAG && idx_pnp)
			plaus_bad = 1'b0;
		volt_bad = st_reg.ctrl[CTRL_SUPV_VOLT] &&
			((supervision_mv_i < st_reg.volt_lo) ||
			(supervision_mv_i > st_reg.volt_hi) ||
			(supervision_mv_i > SUPV_MAX_MV));

		err_now[ERR_AB]    = ab_fault;
		err_now[ERR_Z]     = z_fault;
		err_now[ERR_S]     = s_fault || volt_bad;
		err_now[ERR_PLAUS] = plaus_bad;
		err_now[ERR_FMAX]  = f_ab > fmax;
		err_now[ERR_SEL]   = (basic == BASIC_OFF) && (mode == SEL_ONE_OF_FOUR) &&
			commit && !onehot_ok;
		// a new fault in the acknowledge cycle still latches
		if (fire_ack)
			st_next.err = err_now;
		else
			st_next.err = st_reg.err | err_now;

		// ****************************************
		// direction monitors
		// ****************************************
		if (st_reg.restart) begin
			st_next.wrong_l = '0;
			st_next.wrong_r = '0;
		end else if (dir_pulse_i) begin
			if (dir_left_i) begin
				st_next.wrong_l = '0;
				if (st_reg.wrong_r <= WRONG_DIR_PULSES)
					st_next.wrong_r = st_reg.wrong_r + 4'h1;
			end else begin
				st_next.wrong_r = '0;
				if (st_reg.wrong_l <= WRONG_DIR_PULSES)
					st_next.wrong_l = st_reg.wrong_l + 4'h1;
			end
		end
		left_ok  = st_reg.wrong_l <= WRONG_DIR_PULSES;
		right_ok = st_reg.wrong_r <= WRONG_DIR_PULSES;

		// ****************************************
		// outputs: automatic start, no switch delay
		// ****************************************
		run = (st_reg.err == '0) && !st_reg.restart && !fire_restart;
		st_next.outs[0] = run && st_reg.stand_on;
		st_next.outs[1] = run && st_reg.speed_ok;
		st_next.outs[2] = run && st_reg.stand_on;
		st_next.outs[3] = run && st_reg.speed_ok;
		st_next.outs[4] = run && (basic == BASIC_ENCODER) && left_ok;
		st_next.outs[5] = run && (basic == BASIC_ENCODER) && right_ok;
		st_next.outs[6] = run && (basic == BASIC_ENCODER) && left_ok;
		st_next.outs[7] = run && (basic == BASIC_ENCODER) && right_ok;

		// ****************************************
		// register port
		// ****************************************
		if (wr_en_i) begin
			if (addr_i == ADDR_CTRL)
				st_next.ctrl = wr_data_i[5:0];
			else if (addr_i == ADDR_SEL_DELAY)
				st_next.sel_delay = wr_data_i[15:0];
			else if (addr_i == ADDR_SPECIAL)
				st_next.special = wr_data_i;
			else if (addr_i == ADDR_TOL_AB)
				st_next.tol_ab = wr_data_i[15:0];
			else if (addr_i == ADDR_TOL_Z)
				st_next.tol_z = wr_data_i[15:0];
			else if (addr_i == ADDR_TOL_S)
				st_next.tol_s = wr_data_i[15:0];
			else if (addr_i == ADDR_STANDSTILL)
				st_next.standstill = wr_data_i[23:0];
			else if (addr_i == ADDR_OVERSPEED)
				st_next.overspeed = wr_data_i[23:0];
			else if (addr_i == ADDR_RATIO)
				st_next.ratio = wr_data_i[7:0];
			else if (addr_i == ADDR_VOLT_LIM) begin
				st_next.volt_lo = wr_data_i[15:0];
				st_next.volt_hi = wr_data_i[VOLT_HI_LSB +: 16];
			end
		end
		st_next.rd_data = '0;
		if (rd_en_i) begin
			if (addr_i == ADDR_CTRL)
				st_next.rd_data = {26'h0, st_reg.ctrl};
			else if (addr_i == ADDR_SEL_DELAY)
				st_next.rd_data = {16'h0, st_reg.sel_delay};
			else if (addr_i == ADDR_SPECIAL)
				st_next.rd_data = st_reg.special;
			else if (addr_i == ADDR_TOL_AB)
				st_next.rd_data = {16'h0, st_reg.tol_ab};
			else if (addr_i == ADDR_TOL_Z)
				st_next.rd_data = {16'h0, st_reg.tol_z};
			else if (addr_i == ADDR_TOL_S)
				st_next.rd_data = {16'h0, st_reg.tol_s};
			else if (addr_i == ADDR_STANDSTILL)
				st_next.rd_data = {8'h0, st_reg.standstill};
			else if (addr_i == ADDR_OVERSPEED)
				st_next.rd_data = {8'h0, st_reg.overspeed};
			else if (addr_i == ADDR_RATIO)
				st_next.rd_data = {24'h0, st_reg.ratio};
			else if (addr_i == ADDR_VOLT_LIM)
				st_next.rd_data = {st_reg.volt_hi, st_reg.volt_lo};
			else if (addr_i == ADDR_STATUS)
				st_next.rd_data = {11'h0, st_reg.restart, st_reg.outs,
					2'h0, st_reg.err, st_reg.active};
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg            <= '0;
			st_reg.ctrl       <= RST_CTRL;
			st_reg.sel_delay  <= RST_SEL_DELAY;
			st_reg.special    <= RST_SPECIAL;
			st_reg.tol_ab     <= RST_TOL;
			st_reg.tol_z      <= RST_TOL;
			st_reg.tol_s      <= RST_TOL;
			st_reg.standstill <= RST_THRESHOLD;
			st_reg.overspeed  <= RST_THRESHOLD;
			st_reg.ratio      <= RST_RATIO;
			st_reg.volt_lo    <= RST_VOLT_LO;
			st_reg.volt_hi    <= RST_VOLT_HI;
			st_reg.armed      <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data_o          = st_reg.rd_data;
	assign relay_out_one_o    = st_reg.outs[0];
	assign relay_out_two_o    = st_reg.outs[1];
	assign semi_out_one_o     = st_reg.outs[2];
	assign semi_out_two_o     = st_reg.outs[3];
	assign external_out_one_o = st_reg.outs[4];
	assign external_out_two_o = st_reg.outs[5];
	assign semi_out_three_o   = st_reg.outs[6];
	assign semi_out_four_o    = st_reg.outs[7];
	assign restart_o          = st_reg.restart;
	assign active_set_o       = st_reg.active;
endmodule

// *** bench/psf_checker.sv ***
`timescale 1ns/1ps
module psf_checker import psf_pkg::*; (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic        rd_en_i,
	input  wire logic [31:0] rd_data_o,
	input  wire logic        relay_out_one_o,
	input  wire logic        relay_out_two_o,
	input  wire logic        semi_out_one_o,
	input  wire logic        semi_out_two_o,
	input  wire logic        semi_out_three_o,
	input  wire logic        semi_out_four_o,
	input  wire logic        external_out_one_o,
	input  wire logic        external_out_two_o,
	input  wire logic        restart_o,
	input  wire logic [3:0]  active_set_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	logic [3:0] set_prev_reg;
	logic       set_chg;
	logic       all_off;

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			set_prev_reg <= 4'h0;
		end else begin
			set_prev_reg <= active_set_o;
		end
	end
	assign set_chg = (set_prev_reg != active_set_o);
	assign all_off = ~|{relay_out_one_o, relay_out_two_o, semi_out_one_o, semi_out_two_o,
		semi_out_three_o, semi_out_four_o, external_out_one_o, external_out_two_o};

	// ****************************************
	// assertions
	// ****************************************
	rd_idle_a: assert property (!$past(rd_en_i) |-> rd_data_o == 32'h0)
		else $error("read data not zero outside read answer");
	rd_unmapped_a: assert property ($past(rd_en_i) && $past(addr_i) > ADDR_STATUS |->
		rd_data_o == 32'h0) else $error("unmapped read not zero");
	status_set_a: assert property ($past(rd_en_i) && $past(addr_i) == ADDR_STATUS |->
		rd_data_o[3:0] == $past(active_set_o)) else $error("status set field wrong");
	restart_single_a: assert property (restart_o |=> !restart_o [*3])
		else $error("restart pulse repeated");
	restart_cause_a: assert property (restart_o |-> $past(set_chg))
		else $error("restart without set change");
	restart_off_a: assert property (restart_o |-> all_off ##1 all_off)
		else $error("outputs on during restart");
	standstill_pair_a: assert property (relay_out_one_o == semi_out_one_o)
		else $error("standstill outputs differ");
	speed_pair_a: assert property (relay_out_two_o == semi_out_two_o)
		else $error("speed outputs differ");
	left_pair_a: assert property (external_out_one_o == semi_out_three_o)
		else $error("left outputs differ");
	right_pair_a: assert property (external_out_two_o == semi_out_four_o)
		else $error("right outputs differ");

	cover property (restart_o);
	cover property (set_chg);
	cover property ($past(rd_en_i) && $past(addr_i) == ADDR_STATUS);
endmodule

// *** bench/sensor_model.sv ***
`timescale 1ns/1ps
module sensor_model import psf_pkg::*; (
	input  wire logic        core_clk_i,
	input  wire logic [3:0]  set_req_i,
	input  wire logic        bounce_i,
	input  wire logic [23:0] speed_hz_i,
	output logic [3:0]       sel_o,
	output logic [23:0]      ab_freq_o,
	output logic [23:0]      z_freq_o,
	output logic             dir_pulse_o,
	output logic             dir_left_o
);
	logic [3:0] last_req;
	logic [1:0] glitch;
	logic       hop;

	initial begin
		sel_o = 4'h0;
		ab_freq_o = 24'h0;
		z_freq_o = 24'h0;
		dir_pulse_o = 1'b0;
		dir_left_o = 1'b0;
		last_req = 4'h0;
		glitch = 2'h0;
	end
	assign hop = (set_req_i != last_req) && bounce_i;

	// a switch lever passes a wrong pattern for three cycles before settling
	always @(posedge core_clk_i) begin
		last_req <= set_req_i;
		glitch <= hop ? 2'h2 : (glitch != 2'h0) ? glitch - 2'h1 : 2'h0;
		sel_o <= (hop || glitch != 2'h0) ? set_req_i ^ 4'h5 : set_req_i;
		ab_freq_o <= speed_hz_i;
		z_freq_o <= speed_hz_i;
	end

	task spin(input int n, input logic left);
		repeat (n) begin
			@(posedge core_clk_i);
			dir_left_o <= left;
			dir_pulse_o <= 1'b1;
			@(posedge core_clk_i);
			dir_pulse_o <= 1'b0;
		end
	endtask
endmodule

// *** bench/test_param_set_special_functions.sv ***
`timescale 1ns/1ps
module test_param_set_special_functions import psf_pkg::*;;
	logic        core_clk_i, sys_rst_i, wr_en_i, rd_en_i, bounce;
	logic [7:0]  addr_i;
	logic [31:0] wr_data_i, rd_data_o, d;
	logic [3:0]  sel_i, set_req, active_set_o;
	logic        ab_invalid_i, z_invalid_i, supervision_fault_i, dir_pulse_i, dir_left_i;
	logic [15:0] supervision_mv_i;
	logic [23:0] ab_track_frequency_i, index_track_frequency_i, speed;
	logic        relay_out_one_o, relay_out_two_o, semi_out_one_o, semi_out_two_o;
	logic        semi_out_three_o, semi_out_four_o, external_out_one_o, external_out_two_o;
	logic        restart_o;
	int          n_fail, n_tests, n_rst, r0;

	param_set_special_functions i_param_set_special_functions (.*);
	sensor_model i_sensor_model (.core_clk_i(core_clk_i), .set_req_i(set_req), .bounce_i(bounce),
		.speed_hz_i(speed), .sel_o(sel_i), .ab_freq_o(ab_track_frequency_i),
		.z_freq_o(index_track_frequency_i), .dir_pulse_o(dir_pulse_i), .dir_left_o(dir_left_i));

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (restart_o === 1'b1) n_rst++;
	end

	// ****************************************
	// helpers
	// ****************************************
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_i);
		addr_i <= a;
		wr_data_i <= v;
		wr_en_i <= 1'b1;
		@(posedge core_clk_i);
		wr_en_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge core_clk_i);
		rd_en_i <= 1'b0;
		#1 v = rd_data_o;
	endtask
	task settle(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task spd(input logic [23:0] v);
		@(posedge core_clk_i);
		speed <= v;
		settle(12);
	endtask
	task go(input logic [3:0] s);
		int i;
		@(posedge core_clk_i);
		set_req <= s;
		for (i = 0; i < 60 && active_set_o !== s; i++) @(posedge core_clk_i);
		settle(8);
		chk("active_set", {28'h0, s}, {28'h0, active_set_o});
	endtask
	task err_chk(input int b, input logic e);
		rd(ADDR_STATUS, d);
		chk("status_err", {31'h0, e}, {31'h0, d[STAT_ERR_LSB+b]});
	endtask
	function automatic logic [31:0] outs();
		return {28'h0, relay_out_one_o, relay_out_two_o, external_out_one_o, external_out_two_o};
	endfunction
	task end_of_test();
		if (n_fail == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		{n_fail, n_tests, n_rst} = '0;
		sys_rst_i = 1'b1;
		{addr_i, wr_data_i, wr_en_i, rd_en_i, set_req, bounce, speed} = '0;
		{ab_invalid_i, z_invalid_i, supervision_fault_i} = 3'h0;
		supervision_mv_i = 16'd24000;
		repeat (4) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		settle(2);
		rd(ADDR_RATIO, d);
		chk("ratio", 32'h1, d);
		rd(ADDR_VOLT_LIM, d);
		chk("volt_lim", {RST_VOLT_HI, RST_VOLT_LO}, d);
		rd(ADDR_SPECIAL, d);
		chk("special", RST_SPECIAL, d);
		wr(ADDR_CTRL, 32'h6);
		spd(24'd0);
		chk("prox_outs", 32'hc, outs());
		go(4'h0);
		@(posedge core_clk_i);
		set_req <= 4'h5;
		settle(30);
		chk("set_ignored", 32'h0, {28'h0, active_set_o});
		set_req <= 4'h0;
		spd(24'd1000);
		chk("prox_outs", 32'h0, outs());
		spd(24'd300);
		chk("prox_outs", 32'h4, outs());
		wr(ADDR_CTRL, 32'h8);
		spd(24'd50);
		chk("enc_outs", 32'hf, outs());
		spd(24'd200);
		chk("enc_outs", 32'h7, outs());
		spd(24'd6000);
		chk("enc_outs", 32'h3, outs());
		spd(24'd50);
		i_sensor_model.spin(10, 1'b0);
		settle(6);
		chk("dir_outs", 32'hf, outs());
		i_sensor_model.spin(1, 1'b0);
		settle(6);
		chk("dir_outs", 32'hd, outs());
		wr(ADDR_CTRL, 32'h12);
		wr(ADDR_SEL_DELAY, 32'h3);
		wr(ADDR_SPECIAL, 32'he4);
		wr(ADDR_TOL_AB, 32'h2);
		rd(ADDR_CTRL, d);
		chk("ctrl", 32'h12, d);
		bounce <= 1'b1;
		r0 = n_rst;
		go(4'h3);
		chk("restarts", 1, n_rst - r0);
		go(4'h0);
		go(4'h3);
		chk("restarts", 2, n_rst - r0);
		go(4'h0);
		chk("restarts", 2, n_rst - r0);
		go(4'h1);
		wr(ADDR_RATIO, 32'h2);
		spd(24'd1000);
		err_chk(ERR_PLAUS, 1'b0);
		go(4'h0);
		err_chk(ERR_PLAUS, 1'b1);
		wr(ADDR_RATIO, 32'h1);
		go(4'h2);
		chk("restarts", 3, n_rst - r0);
		err_chk(ERR_PLAUS, 1'b0);
		ab_invalid_i <= 1'b1;
		settle(20);
		ab_invalid_i <= 1'b0;
		settle(5);
		err_chk(ERR_AB, 1'b1);
		go(4'h0);
		go(4'h2);
		err_chk(ERR_AB, 1'b0);
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_OVERSPEED, 32'h7d0);
		settle(4);
		chk("sel_err_outs", 32'h4, outs());
		set_req <= 4'h3;
		settle(30);
		err_chk(ERR_SEL, 1'b1);
		chk("sel_err_outs", 32'h0, outs());
		wr(ADDR_CTRL, 32'h0);
		settle(30);
		chk("set_none", 32'h0, {28'h0, active_set_o});
		rd(8'h2c, d);
		chk("unmapped", 32'h0, d);
		wr(ADDR_CTRL, 32'h20);
		settle(4);
		err_chk(ERR_S, 1'b0);
		wr(ADDR_VOLT_LIM, 32'h7530_61a8);
		settle(4);
		err_chk(ERR_S, 1'b1);
		end_of_test();
	end

	initial begin
		#200000;
		n_fail++;
		end_of_test();
	end
endmodule

bind param_set_special_functions psf_checker i_psf_checker (.*);
